// ---- include/pwd_regs.svh ----
// Timing counts, thresholds and oscillator defaults for the dual reset and window watchdog block
`ifndef PWD_REGS_SVH
`define PWD_REGS_SVH

`define PWD_CLK_PERIOD_NS 20
`define PWD_CNT_W 7
`define PWD_POR_CYCLES 7'h40
`define PWD_DLY_CYCLES 7'h21
`define PWD_WDL_CYCLES 7'h04
`define PWD_WDU_CYCLES 7'h40
`define PWD_HV_THRESH_MV 1150
`define PWD_LV_THRESH_MV 550
`define PWD_RST_OSC_PERIOD_NS 4734375
`define PWD_WDT_OSC_PERIOD_NS 4734375

`endif

// ---- include/pwd_pkg.sv ----
// Types shared by the dual reset and window watchdog block
package pwd_pkg;

	typedef enum logic [4:0] {
		WD_OFF = 5'h01,
		WD_DELAY = 5'h02,
		WD_ARM = 5'h04,
		WD_WIN = 5'h08,
		WD_FAULT = 5'h10
	} pwd_wd_state_t;

	typedef struct packed {
		logic fb_hv;
		logic fb_lv;
		logic enable_n;
		logic kick;
		logic pin_hv;
		logic pin_lv;
	} pwd_pins_t;

	typedef struct packed {
		pwd_pins_t stage1;
		pwd_pins_t stage2;
	} pwd_sync_state_t;

	typedef struct packed {
		logic [31:0] phase;
		logic tick;
	} pwd_osc_state_t;

	typedef struct packed {
		logic [6:0] hv_cnt;
		logic [6:0] lv_cnt;
		logic hv_released;
		logic lv_released;
		pwd_wd_state_t wd_state;
		logic [6:0] wd_cnt;
		logic [6:0] fault_cnt;
		logic kick_prev;
		logic hv_oe;
		logic lv_oe;
		logic fault_oe;
		logic drive_low;
	} pwd_top_state_t;

endpackage

// ---- design/pwd_sync.sv ----
// Two-stage synchroniser for every pin level that the block reads
`timescale 1ns/1ns
`default_nettype none

module pwd_sync
(
	input wire logic clk,
	input wire logic rst,
	input pwd_pkg::pwd_pins_t pins_async,
	output pwd_pkg::pwd_pins_t pins_sync
);
	import pwd_pkg::*;

	pwd_sync_state_t st;
	pwd_sync_state_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.stage1 = pins_async;
		next_st.stage2 = st.stage1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign pins_sync = st.stage2;

endmodule

`default_nettype wire

// ---- design/pwd_osc.sv ----
// Timing oscillator: one tick pulse every DIV clocks while run is high
`timescale 1ns/1ns
`default_nettype none

module pwd_osc
#(
	parameter int unsigned DIV = 2
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic restart,
	output logic tick
);
	import pwd_pkg::*;

	pwd_osc_state_t st;
	pwd_osc_state_t next_st;

	generate
		if (DIV < 2)
		begin : g_div_check
			$error("pwd_osc: DIV must be at least 2");
		end
	endgenerate

	// A stopped or restarted oscillator starts a full period from zero
	always_comb
	begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!run || restart)
		begin
			next_st.phase = '0;
		end
		else if (st.phase == 32'(DIV - 1))
		begin
			next_st.phase = '0;
			next_st.tick = 1'b1;
		end
		else
		begin
			next_st.phase = st.phase + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

endmodule

`default_nettype wire

// ---- design/pwd_top.sv ----
// Dual-channel power-on reset timers and window watchdog
`timescale 1ns/1ns
`default_nettype none
`include "pwd_regs.svh"

// Functional notes
// - Both power-good comparator results are watched from reset release onward, high channel at 1.15V, low at 550mV.
// - The two reset outputs and the fault output only pull low or release, a weak pull-up gives the high level.
// - Both channel timers count one shared reset-timer oscillator and each timeout is 64 of its cycles.
// - A channel whose feedback is good runs the reset-timer oscillator and releases its reset after the timeout.
// - The watchdog works only while its active-low enable input is held low by the outside party.
// - Once both resets are released the watchdog oscillator starts and kicks are ignored for 33 of its cycles.
// - After that delay only falling edges of the kick input count as service events.
// - The window between consecutive kick falling edges runs from 4 to 64 watchdog-oscillator cycles.
// - Kicks closer than 4 or further apart than 64 cycles pull the fault output low for one reset timeout.
// - When the fault output is released the ignore delay starts again before kicks are checked.
// - A kick inside the window restarts the watchdog count, keeps the reset-timer oscillator stopped, fault stays high.
module pwd_top
#(
	parameter int unsigned RST_OSC_PERIOD_NS = `PWD_RST_OSC_PERIOD_NS,
	parameter int unsigned WDT_OSC_PERIOD_NS = `PWD_WDT_OSC_PERIOD_NS
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic feedback_hv_chan,
	input wire logic feedback_lv_chan,
	input wire logic watchdog_enable_n,
	input wire logic watchdog_kick_in,
	input wire logic reset_out_hv_chan_n_i,
	output logic reset_out_hv_chan_n_o,
	output logic reset_out_hv_chan_n_oe,
	input wire logic reset_out_lv_chan_n_i,
	output logic reset_out_lv_chan_n_o,
	output logic reset_out_lv_chan_n_oe,
	input wire logic watchdog_fault_out_n_i,
	output logic watchdog_fault_out_n_o,
	output logic watchdog_fault_out_n_oe
);
	import pwd_pkg::*;

	localparam int unsigned RST_OSC_CYCLES = RST_OSC_PERIOD_NS / `PWD_CLK_PERIOD_NS;
	localparam int unsigned WDT_OSC_CYCLES = WDT_OSC_PERIOD_NS / `PWD_CLK_PERIOD_NS;
	localparam int unsigned HV_THRESH_MV = `PWD_HV_THRESH_MV;
	localparam int unsigned LV_THRESH_MV = `PWD_LV_THRESH_MV;

	localparam pwd_top_state_t RESET_STATE = '{
		hv_cnt: '0,
		lv_cnt: '0,
		hv_released: 1'b0,
		lv_released: 1'b0,
		wd_state: WD_OFF,
		wd_cnt: '0,
		fault_cnt: '0,
		kick_prev: 1'b1,
		hv_oe: 1'b1,
		lv_oe: 1'b1,
		fault_oe: 1'b0,
		drive_low: 1'b0
	};

	generate
		if (RST_OSC_CYCLES < 2 || WDT_OSC_CYCLES < 2)
		begin : g_period_check
			$error("pwd_top: oscillator periods must span at least two clocks");
		end
		if (HV_THRESH_MV == 0 || LV_THRESH_MV == 0)
		begin : g_thresh_check
			$error("pwd_top: comparator thresholds must be non-zero");
		end
	endgenerate

	pwd_top_state_t st;
	pwd_top_state_t next_st;
	pwd_pins_t pins_async;
	pwd_pins_t pins;
	logic rst_osc_run;
	logic rst_tick;
	logic wdt_osc_run;
	logic wdt_restart;
	logic wdt_tick;
	logic kick_fall;
	logic hv_pending;
	logic lv_pending;
	logic wd_allowed;
	logic [6:0] win_cnt;

	// Comparator results and pin read-backs enter through the synchroniser
	always_comb
	begin
		pins_async.fb_hv = feedback_hv_chan;
		pins_async.fb_lv = feedback_lv_chan;
		pins_async.enable_n = watchdog_enable_n;
		pins_async.kick = watchdog_kick_in;
		pins_async.pin_hv = reset_out_hv_chan_n_i;
		pins_async.pin_lv = reset_out_lv_chan_n_i;
	end

	pwd_sync u_sync
	(
		.clk(clk),
		.rst(rst),
		.pins_async(pins_async),
		.pins_sync(pins)
	);

	// Channel timers waiting on the shared oscillator
	always_comb
	begin
		hv_pending = pins.fb_hv && !st.hv_released;
		lv_pending = pins.fb_lv && !st.lv_released;
		rst_osc_run = hv_pending || lv_pending || (st.wd_state == WD_FAULT);
	end

	pwd_osc
	#(
		.DIV(RST_OSC_CYCLES)
	)
	u_rst_osc
	(
		.clk(clk),
		.rst(rst),
		.run(rst_osc_run),
		.restart(1'b0),
		.tick(rst_tick)
	);

	// Watchdog sees the wired levels, so an outside party holding a reset low keeps it idle
	always_comb
	begin
		wd_allowed = !pins.enable_n && st.hv_released && st.lv_released && pins.pin_hv && pins.pin_lv;
		kick_fall = st.kick_prev && !pins.kick;
		wdt_osc_run = (st.wd_state == WD_DELAY) || (st.wd_state == WD_ARM) || (st.wd_state == WD_WIN);
		wdt_restart = kick_fall && ((st.wd_state == WD_ARM) || (st.wd_state == WD_WIN));
		// A tick that lands with the edge has completed and counts toward the lower bound
		win_cnt = st.wd_cnt + {6'h00, wdt_tick};
	end

	pwd_osc
	#(
		.DIV(WDT_OSC_CYCLES)
	)
	u_wdt_osc
	(
		.clk(clk),
		.rst(rst),
		.run(wdt_osc_run),
		.restart(wdt_restart),
		.tick(wdt_tick)
	);

	always_comb
	begin
		next_st = st;
		next_st.kick_prev = pins.kick;
		next_st.drive_low = 1'b0;

		// High-voltage channel reset timer
		if (!pins.fb_hv)
		begin
			next_st.hv_cnt = '0;
			next_st.hv_released = 1'b0;
		end
		else if (!st.hv_released && rst_tick)
		begin
			if (st.hv_cnt == `PWD_POR_CYCLES - 7'h01)
			begin
				next_st.hv_released = 1'b1;
				next_st.hv_cnt = '0;
			end
			else
			begin
				next_st.hv_cnt = st.hv_cnt + 7'h01;
			end
		end

		// Low-voltage channel reset timer
		if (!pins.fb_lv)
		begin
			next_st.lv_cnt = '0;
			next_st.lv_released = 1'b0;
		end
		else if (!st.lv_released && rst_tick)
		begin
			if (st.lv_cnt == `PWD_POR_CYCLES - 7'h01)
			begin
				next_st.lv_released = 1'b1;
				next_st.lv_cnt = '0;
			end
			else
			begin
				next_st.lv_cnt = st.lv_cnt + 7'h01;
			end
		end

		// Window watchdog
		if (!wd_allowed)
		begin
			next_st.wd_state = WD_OFF;
			next_st.wd_cnt = '0;
			next_st.fault_cnt = '0;
		end
		else
		begin
			case (st.wd_state)
				WD_OFF:
				begin
					next_st.wd_state = WD_DELAY;
					next_st.wd_cnt = '0;
				end
				WD_DELAY:
				begin
					if (wdt_tick)
					begin
						if (st.wd_cnt == `PWD_DLY_CYCLES - 7'h01)
						begin
							next_st.wd_state = WD_ARM;
							next_st.wd_cnt = '0;
						end
						else
						begin
							next_st.wd_cnt = st.wd_cnt + 7'h01;
						end
					end
				end
				WD_ARM:
				begin
					if (kick_fall)
					begin
						next_st.wd_state = WD_WIN;
						next_st.wd_cnt = '0;
					end
					else if (wdt_tick && st.wd_cnt == `PWD_WDU_CYCLES - 7'h01)
					begin
						next_st.wd_state = WD_FAULT;
						next_st.fault_cnt = '0;
					end
					else if (wdt_tick)
					begin
						next_st.wd_cnt = st.wd_cnt + 7'h01;
					end
				end
				WD_WIN:
				begin
					if (kick_fall && win_cnt < `PWD_WDL_CYCLES)
					begin
						next_st.wd_state = WD_FAULT;
						next_st.fault_cnt = '0;
					end
					else if (kick_fall)
					begin
						next_st.wd_cnt = '0;
					end
					else if (wdt_tick && st.wd_cnt == `PWD_WDU_CYCLES - 7'h01)
					begin
						next_st.wd_state = WD_FAULT;
						next_st.fault_cnt = '0;
					end
					else if (wdt_tick)
					begin
						next_st.wd_cnt = st.wd_cnt + 7'h01;
					end
				end
				WD_FAULT:
				begin
					if (rst_tick)
					begin
						if (st.fault_cnt == `PWD_POR_CYCLES - 7'h01)
						begin
							next_st.wd_state = WD_DELAY;
							next_st.wd_cnt = '0;
							next_st.fault_cnt = '0;
						end
						else
						begin
							next_st.fault_cnt = st.fault_cnt + 7'h01;
						end
					end
				end
				default:
				begin
					next_st.wd_state = WD_OFF;
				end
			endcase
		end

		// Open-drain enables, high while the pin is pulled low
		next_st.hv_oe = !next_st.hv_released;
		next_st.lv_oe = !next_st.lv_released;
		next_st.fault_oe = (next_st.wd_state == WD_FAULT);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st <= RESET_STATE;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign reset_out_hv_chan_n_o = st.drive_low;
	assign reset_out_hv_chan_n_oe = st.hv_oe;
	assign reset_out_lv_chan_n_o = st.drive_low;
	assign reset_out_lv_chan_n_oe = st.lv_oe;
	assign watchdog_fault_out_n_o = st.drive_low;
	assign watchdog_fault_out_n_oe = st.fault_oe;

endmodule

`default_nettype wire

// ---- tb/pwd_top_checker.sv ----
// Assertion checker for the reset timers and window watchdog
`timescale 1ns/1ns
`default_nettype none
module pwd_top_checker
#(
	parameter int unsigned RST_OSC_PERIOD_NS = 100,
	parameter int unsigned WDT_OSC_PERIOD_NS = 100
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic feedback_hv_chan,
	input wire logic feedback_lv_chan,
	input wire logic watchdog_enable_n,
	input wire logic watchdog_kick_in,
	input wire logic reset_out_hv_chan_n_i,
	input wire logic reset_out_hv_chan_n_o,
	input wire logic reset_out_hv_chan_n_oe,
	input wire logic reset_out_lv_chan_n_i,
	input wire logic reset_out_lv_chan_n_o,
	input wire logic reset_out_lv_chan_n_oe,
	input wire logic watchdog_fault_out_n_i,
	input wire logic watchdog_fault_out_n_o,
	input wire logic watchdog_fault_out_n_oe
);
	localparam int RC = RST_OSC_PERIOD_NS / 20;
	localparam int WC = WDT_OSC_PERIOD_NS / 20;
	logic [9:0] hv_up;
	logic [9:0] lv_up;
	logic [9:0] flt_len;
	logic [9:0] quiet;
	logic [9:0] gap;
	logic kick_d;
	logic wd_hold;
	function automatic logic [9:0] inc(input logic [9:0] x);
		return x + {9'h000, ~&x};
	endfunction
	// Watchdog cannot be running while any of these holds
	assign wd_hold = reset_out_hv_chan_n_oe | reset_out_lv_chan_n_oe | watchdog_fault_out_n_oe | watchdog_enable_n;
	always_ff @(posedge clk)
	begin
		kick_d <= watchdog_kick_in;
		hv_up <= (rst || !feedback_hv_chan) ? 10'h000 : inc(hv_up);
		lv_up <= (rst || !feedback_lv_chan) ? 10'h000 : inc(lv_up);
		flt_len <= (rst || !watchdog_fault_out_n_oe) ? 10'h000 : inc(flt_len);
		quiet <= (rst || wd_hold) ? 10'h000 : inc(quiet);
		gap <= (rst || (kick_d && !watchdog_kick_in)) ? 10'h000 : inc(gap);
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_od;
		!(reset_out_hv_chan_n_o | reset_out_lv_chan_n_o | watchdog_fault_out_n_o);
	endproperty
	a_od: assert property (p_od) else $error("open-drain output driven high");
	property p_hv_rel;
		$fell(reset_out_hv_chan_n_oe) |-> hv_up >= 63 * RC && hv_up <= 65 * RC + 4;
	endproperty
	a_hv_rel: assert property (p_hv_rel) else $error("high channel timeout wrong");
	property p_lv_rel;
		$fell(reset_out_lv_chan_n_oe) |-> lv_up >= 63 * RC && lv_up <= 65 * RC + 4;
	endproperty
	a_lv_rel: assert property (p_lv_rel) else $error("low channel timeout wrong");
	property p_hv_loss;
		$fell(feedback_hv_chan) |-> ##[1:4] reset_out_hv_chan_n_oe;
	endproperty
	a_hv_loss: assert property (p_hv_loss) else $error("high reset not reasserted");
	property p_lv_loss;
		$fell(feedback_lv_chan) |-> ##[1:4] reset_out_lv_chan_n_oe;
	endproperty
	a_lv_loss: assert property (p_lv_loss) else $error("low reset not reasserted");
	property p_flt_len;
		$fell(watchdog_fault_out_n_oe) && hv_up > 8 && lv_up > 8 && !watchdog_enable_n && !$past(watchdog_enable_n, 3)
			|-> flt_len >= 63 * RC && flt_len <= 65 * RC + 2;
	endproperty
	a_flt_len: assert property (p_flt_len) else $error("fault pulse length wrong");
	property p_en_off;
		watchdog_enable_n [*4] |-> !watchdog_fault_out_n_oe;
	endproperty
	a_en_off: assert property (p_en_off) else $error("fault while disabled");
	property p_rst_off;
		(reset_out_hv_chan_n_oe || reset_out_lv_chan_n_oe) [*4] |-> !watchdog_fault_out_n_oe;
	endproperty
	a_rst_off: assert property (p_rst_off) else $error("fault while a reset is held");
	property p_delay;
		$rose(watchdog_fault_out_n_oe) |-> quiet >= 33 * WC;
	endproperty
	a_delay: assert property (p_delay) else $error("fault inside ignore delay");
	property p_expiry;
		gap > 64 * WC + 8 |-> quiet <= 97 * WC + 20;
	endproperty
	a_expiry: assert property (p_expiry) else $error("missed upper bound expiry");
	c_fault: cover property ($rose(watchdog_fault_out_n_oe));
	c_hv: cover property ($fell(reset_out_hv_chan_n_oe));
	c_lv: cover property ($fell(reset_out_lv_chan_n_oe));
endmodule
bind pwd_top pwd_top_checker #(.RST_OSC_PERIOD_NS(RST_OSC_PERIOD_NS), .WDT_OSC_PERIOD_NS(WDT_OSC_PERIOD_NS)) u_chk (
	.clk(clk), .rst(rst), .feedback_hv_chan(feedback_hv_chan), .feedback_lv_chan(feedback_lv_chan),
	.watchdog_enable_n(watchdog_enable_n), .watchdog_kick_in(watchdog_kick_in),
	.reset_out_hv_chan_n_i(reset_out_hv_chan_n_i), .reset_out_hv_chan_n_o(reset_out_hv_chan_n_o),
	.reset_out_hv_chan_n_oe(reset_out_hv_chan_n_oe), .reset_out_lv_chan_n_i(reset_out_lv_chan_n_i),
	.reset_out_lv_chan_n_o(reset_out_lv_chan_n_o), .reset_out_lv_chan_n_oe(reset_out_lv_chan_n_oe),
	.watchdog_fault_out_n_i(watchdog_fault_out_n_i), .watchdog_fault_out_n_o(watchdog_fault_out_n_o),
	.watchdog_fault_out_n_oe(watchdog_fault_out_n_oe));
`default_nettype wire

// ---- tb/pwd_host.sv ----
// Host model that kicks the watchdog at a set spacing of clocks
`timescale 1ns/1ns
`default_nettype none
module pwd_host
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [9:0] period,
	output logic kick
);
	logic [9:0] cnt;
	// Falling edge once per period, low for two clocks; zero period stops kicking
	always_ff @(posedge clk)
	begin
		if (rst || period == 10'h000)
			cnt <= 10'h002;
		else
			cnt <= (cnt >= period - 10'h001) ? 10'h000 : cnt + 10'h001;
	end
	assign kick = (cnt >= 10'h002);
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the reset timers and window watchdog
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic fbh = 1'b0;
	logic fbl = 1'b0;
	logic en_n = 1'b1;
	logic [9:0] per = 10'h000;
	logic kick;
	logic hv_oe;
	logic lv_oe;
	logic f_oe;
	logic hv_pin;
	logic lv_pin;
	logic f_pin;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [9:0] wp [3] = '{10'h015, 10'h032, 10'h136};
	// Weak pull-ups resolve each released pin high
	assign hv_pin = ~hv_oe;
	assign lv_pin = ~lv_oe;
	assign f_pin = ~f_oe;
	pwd_top #(.RST_OSC_PERIOD_NS(100), .WDT_OSC_PERIOD_NS(100)) DUT (
		.clk(clk), .rst(rst), .feedback_hv_chan(fbh), .feedback_lv_chan(fbl),
		.watchdog_enable_n(en_n), .watchdog_kick_in(kick),
		.reset_out_hv_chan_n_i(hv_pin), .reset_out_hv_chan_n_o(), .reset_out_hv_chan_n_oe(hv_oe),
		.reset_out_lv_chan_n_i(lv_pin), .reset_out_lv_chan_n_o(), .reset_out_lv_chan_n_oe(lv_oe),
		.watchdog_fault_out_n_i(f_pin), .watchdog_fault_out_n_o(), .watchdog_fault_out_n_oe(f_oe));
	pwd_host HOST (.clk(clk), .rst(rst), .period(per), .kick(kick));
	always #10 clk = ~clk;
	task automatic final_report;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 12000)
		begin
			errors++;
			final_report();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_f(input logic lvl, output int n);
		n = 0;
		while (f_oe !== lvl && n < 700)
		begin
			cyc(1);
			n++;
		end
	endtask
	task automatic calm(input int len, output int n);
		n = 0;
		repeat (len)
		begin
			cyc(1);
			if (f_oe !== 1'b0)
				n++;
		end
	endtask
	task automatic t_por;
		fbh = 1'b1;
		cyc(30);
		fbl = 1'b1;
		cyc(280);
		check(hv_pin, 1'b0);
		cyc(25);
		check(hv_pin, 1'b1);
		check(lv_pin, 1'b0);
		cyc(25);
		check(lv_pin, 1'b1);
		check(f_pin, 1'b1);
	endtask
	task automatic t_win;
		int n;
		en_n = 1'b0;
		foreach (wp[i])
		begin
			per = wp[i];
			calm(1300, n);
			check(16'(n), 16'h0000);
		end
	endtask
	task automatic t_fast;
		int n;
		per = 10'h00a;
		wait_f(1'b1, n);
		check(f_pin, 1'b0);
		wait_f(1'b0, n);
		check(16'(n >= 313 && n <= 330), 16'h0001);
		per = 10'h032;
		calm(1000, n);
		check(16'(n), 16'h0000);
	endtask
	task automatic t_slow;
		int n;
		per = 10'h000;
		wait_f(1'b1, n);
		check(16'(n >= 270 && n <= 335), 16'h0001);
	endtask
	task automatic t_en;
		int n;
		en_n = 1'b1;
		cyc(5);
		calm(800, n);
		check(16'(n), 16'h0000);
		en_n = 1'b0;
		wait_f(1'b1, n);
		check(16'(n >= 480 && n <= 500), 16'h0001);
	endtask
	task automatic t_loss;
		per = 10'h032;
		fbh = 1'b0;
		cyc(5);
		check(hv_pin, 1'b0);
		check(lv_pin, 1'b1);
		fbh = 1'b1;
		cyc(310);
		check(hv_pin, 1'b0);
		cyc(25);
		check(hv_pin, 1'b1);
	endtask
	initial
	begin
		cyc(20);
		rst = 1'b0;
		t_por();
		t_win();
		t_fast();
		t_slow();
		t_en();
		t_loss();
		final_report();
	end
endmodule
`default_nettype wire
